// ---- hdl/eqc_regs.svh ----
// Register offsets, field positions, reset values and timing counts.
`ifndef EQC_REGS_SVH
`define EQC_REGS_SVH

`define EQC_OFS_GAIN 7'h03
`define EQC_OFS_OVR 7'h04
`define EQC_OFS_MODE 7'h05

`define EQC_RST_GAIN 8'h20
`define EQC_RST_OVR 8'h00
`define EQC_RST_MODE 8'h00

`define EQC_GAIN_MID 6'h20
`define EQC_COAX_MAX_LEN 6'h14

`define EQC_OVR_HOLD_SEL 0
`define EQC_OVR_HOLD_VAL 1
`define EQC_OVR_OFF_SEL 2
`define EQC_OVR_OFF_VAL 3
`define EQC_OVR_COLOR_SEL 4
`define EQC_OVR_COLOR_VAL 5
`define EQC_OVR_INV_SEL 6
`define EQC_OVR_INV_VAL 7

`define EQC_MODE_LSB 0
`define EQC_FILT_LSB 2
`define EQC_CABLE_BIT 4
`define EQC_MODE_USED 5

`define EQC_ADDR_BITS 8
`define EQC_FRAME_BITS 16

`define EQC_LOSS_TIME_US 1000
`define EQC_CLK_MHZ 100
`define EQC_LOSS_CYCLES (`EQC_LOSS_TIME_US * `EQC_CLK_MHZ)

`endif

// ---- hdl/eqc_pkg.sv ----
// Types shared by the equalizer control register bank.
package eqc_pkg;

  typedef enum logic [1:0] {
    EQC_MODE_CONT = 2'h0,
    EQC_MODE_LOSS = 2'h1,
    EQC_MODE_RESET = 2'h2,
    EQC_MODE_MANUAL = 2'h3
  } eqc_mode_e;

  typedef enum logic [1:0] {
    EQC_FILT_NONE = 2'h0,
    EQC_FILT_MIN = 2'h1,
    EQC_FILT_MAX = 2'h2
  } eqc_filt_e;

  typedef enum logic [0:0] {
    EQC_LK_ADAPT = 1'h0,
    EQC_LK_LOCKED = 1'h1
  } eqc_lock_e;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } eqc_wr_s;

endpackage

// ---- hdl/eqc_serial.sv ----
// Serial control port engine: address byte, then write or read data byte.
`include "eqc_regs.svh"
module eqc_serial (
  input wire logic clk_in,                 // System clock.
  input wire logic resetn_in,              // Synchronous reset, active low.
  input wire logic frame_en_in,            // High while a transfer runs.
  input wire logic sck_in,                 // Serial clock from the host.
  input wire logic sd_in,                  // Serial data pin, input side.
  output logic sd_out,                     // Serial data pin, output side.
  output logic sd_oe_n_out,                // Low while the pin is driven.
  output logic wr_stb_out,                 // One-cycle register write pulse.
  output eqc_pkg::eqc_wr_s wr_out,         // Write address and data.
  output logic [6:0] rd_addr_out,          // Address for read data.
  input wire logic [7:0] rd_data_in        // Read data for rd_addr_out.
);

  logic sck_q_ff;
  logic [4:0] cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] addr_ff;
  logic [7:0] tx_ff;
  logic sd_ff;
  logic drive_ff;
  logic wr_stb_ff;
  eqc_pkg::eqc_wr_s wr_ff;
  logic rise;
  logic [7:0] nxt_shift;

  assign rise = frame_en_in & sck_in & ~sck_q_ff;
  assign nxt_shift = {shift_ff[6:0], sd_in};

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sck_q_ff <= 1'h0;
    end else begin
      sck_q_ff <= sck_in;
    end
  end

  // Bit counter and input shifter, restarted by every new frame.
  always_ff @(posedge clk_in) begin
    if (!resetn_in || !frame_en_in) begin
      cnt_ff <= 5'h00;
      shift_ff <= 8'h00;
      addr_ff <= 8'h00;
    end else if (rise) begin
      shift_ff <= nxt_shift;
      if (cnt_ff != 5'(`EQC_FRAME_BITS)) begin
        cnt_ff <= cnt_ff + 5'h01;
      end
      if (cnt_ff == 5'(`EQC_ADDR_BITS - 1)) begin
        addr_ff <= nxt_shift;
      end
    end
  end

  assign rd_addr_out = nxt_shift[6:0];

  // Write strobe after the data byte of a write frame.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wr_stb_ff <= 1'h0;
      wr_ff <= '0;
    end else begin
      wr_stb_ff <= 1'h0;
      if (rise && !addr_ff[7] &&
          cnt_ff == 5'(`EQC_FRAME_BITS - 1)) begin
        wr_stb_ff <= 1'h1;
        wr_ff <= '{addr: addr_ff[6:0], data: nxt_shift};
      end
    end
  end

  // Read data is captured at the eighth edge and leaves from the ninth on,
  // so the host can latch each bit on the falling edge that follows.
  always_ff @(posedge clk_in) begin
    if (!resetn_in || !frame_en_in) begin
      tx_ff <= 8'h00;
      sd_ff <= 1'h0;
      drive_ff <= 1'h0;
    end else if (rise) begin
      if (cnt_ff == 5'(`EQC_ADDR_BITS - 1)) begin
        tx_ff <= rd_data_in;
      end else if (addr_ff[7] && cnt_ff >= 5'(`EQC_ADDR_BITS) &&
                   cnt_ff < 5'(`EQC_FRAME_BITS)) begin
        drive_ff <= 1'h1;
        sd_ff <= tx_ff[7];
        tx_ff <= {tx_ff[6:0], 1'h0};
      end
    end
  end

  assign sd_out = sd_ff;
  assign sd_oe_n_out = ~drive_ff;
  assign wr_stb_out = wr_stb_ff;
  assign wr_out = wr_ff;

endmodule

// ---- hdl/eqc_ctrl.sv ----
// Equalizer control register bank with pin overrides and locking modes.
//
// Overview of operation
// - Gain code 0x00 max, 0x20 zero, 0x3F min.
// - Manual gain applies only in manual length mode.
// - Hold from pin, or override value when selected.
// - Disable from pin, or override value when selected.
// - Colour mode from pin, or override value.
// - Invert from override value, else pin in manual mode, else detector.
// - Mode: continuous, loss lock, reset lock, manual.
// - Loss lock restarts after 1 ms signal absence.
// - Manual mode disables automatic polarity correction.
// - Filter field: none, minimum, maximum strength.
// - Cable bit selects twisted pair or coax.
// - Cable bit ignored outside manual length mode.
// - Manual length six bits; coax caps 0x14.
// - Address byte: direction bit, seven-bit address.
`include "eqc_regs.svh"
module eqc_ctrl #(
  parameter int LOSS_CYCLES = `EQC_LOSS_CYCLES, // Signal-loss time in cycles.
  parameter bit HAS_FILTER = 1'b1               // Noise filter is fitted.
) (
  input wire logic clk_in,                 // 100 MHz system clock.
  input wire logic resetn_in,              // Synchronous reset, active low.
  input wire logic frame_en_in,            // Serial frame enable.
  input wire logic sck_in,                 // Serial clock.
  input wire logic sd_in,                  // Serial data, input side.
  output logic sd_out,                     // Serial data, output side.
  output logic sd_oe_n_out,                // Low while driving serial data.
  input wire logic hold_pin_in,            // Hold pin level.
  input wire logic eq_off_pin_in,          // Equalizer disable pin level.
  input wire logic color_pin_in,           // Colour pin level.
  input wire logic invert_pin_in,          // Invert pin level.
  input wire logic auto_invert_in,         // Polarity detector result.
  input wire logic signal_present_in,      // Input signal detected.
  input wire logic settled_in,             // Adaptation has settled.
  input wire logic [5:0] manual_len_in,    // Manual length setting.
  output logic hold_out,                   // Freeze equalization.
  output logic eq_off_out,                 // Equalizer disabled.
  output logic color_mode_out,             // 1 colour, 0 monochrome.
  output logic invert_out,                 // Treat input as inverted.
  output logic auto_pol_en_out,            // Polarity corrector enabled.
  output eqc_pkg::eqc_mode_e mode_out,     // Locking mode in force.
  output logic lock_out,                   // Adaptation locked.
  output logic restart_out,                // Pulse: begin re-equalization.
  output logic manual_out,                 // Manual length mode.
  output logic signed [6:0] gain_step_out, // DC gain steps, + is more gain.
  output logic [5:0] eq_len_out,           // Applied manual length.
  output logic coax_out,                   // Coax cable model selected.
  output eqc_pkg::eqc_filt_e filter_out    // Noise filter strength.
);

  logic [5:0] gain_ff;
  logic [7:0] ovr_ff;
  logic [4:0] mode_ff;
  logic wr_stb;
  eqc_pkg::eqc_wr_s wr;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  eqc_pkg::eqc_mode_e mode;
  eqc_pkg::eqc_lock_e lock_ff;
  eqc_pkg::eqc_lock_e nxt_lock;
  logic [31:0] loss_cnt_ff;
  logic restart_ff;
  logic loss_done;

  eqc_serial u_serial (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .frame_en_in(frame_en_in),
    .sck_in(sck_in),
    .sd_in(sd_in),
    .sd_out(sd_out),
    .sd_oe_n_out(sd_oe_n_out),
    .wr_stb_out(wr_stb),
    .wr_out(wr),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data)
  );

  // Register writes take effect on the cycle after the strobe.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      gain_ff <= 6'(`EQC_RST_GAIN);
      ovr_ff <= `EQC_RST_OVR;
      mode_ff <= 5'(`EQC_RST_MODE);
    end else if (wr_stb) begin
      if (wr.addr == `EQC_OFS_GAIN) begin
        gain_ff <= wr.data[5:0];
      end else if (wr.addr == `EQC_OFS_OVR) begin
        ovr_ff <= wr.data;
      end else if (wr.addr == `EQC_OFS_MODE) begin
        mode_ff <= wr.data[4:0];
      end
    end
  end

  // Unmapped addresses read as zero, as do unused upper bits.
  always_comb begin
    if (rd_addr == `EQC_OFS_GAIN) begin
      rd_data = {2'h0, gain_ff};
    end else if (rd_addr == `EQC_OFS_OVR) begin
      rd_data = ovr_ff;
    end else if (rd_addr == `EQC_OFS_MODE) begin
      rd_data = {3'h0, mode_ff};
    end else begin
      rd_data = 8'h00;
    end
  end

  assign mode = eqc_pkg::eqc_mode_e'(mode_ff[1:0]);
  assign manual_out = (mode == eqc_pkg::EQC_MODE_MANUAL);
  assign mode_out = mode;

  // Override selects pick the register value over the pin level.
  assign hold_out = ovr_ff[`EQC_OVR_HOLD_SEL] ?
                    ovr_ff[`EQC_OVR_HOLD_VAL] : hold_pin_in;
  assign eq_off_out = ovr_ff[`EQC_OVR_OFF_SEL] ?
                      ovr_ff[`EQC_OVR_OFF_VAL] : eq_off_pin_in;
  assign color_mode_out = ovr_ff[`EQC_OVR_COLOR_SEL] ?
                          ovr_ff[`EQC_OVR_COLOR_VAL] :
                          color_pin_in;

  // In manual mode the detector result is dropped entirely.
  assign auto_pol_en_out = ~manual_out;
  always_comb begin
    if (ovr_ff[`EQC_OVR_INV_SEL]) begin
      invert_out = ovr_ff[`EQC_OVR_INV_VAL];
    end else if (manual_out) begin
      invert_out = invert_pin_in;
    end else begin
      invert_out = auto_invert_in;
    end
  end

  // Gain steps count away from mid-scale; outside manual mode it is zero.
  always_comb begin
    if (manual_out) begin
      gain_step_out = 7'(signed'({1'b0, `EQC_GAIN_MID}) -
                         signed'({1'b0, gain_ff}));
    end else begin
      gain_step_out = 7'sh00;
    end
  end

  // Coax runs saturate, so longer codes give no extra equalization.
  assign coax_out = manual_out & mode_ff[`EQC_CABLE_BIT];
  always_comb begin
    if (!manual_out) begin
      eq_len_out = 6'h00;
    end else if (coax_out && manual_len_in > `EQC_COAX_MAX_LEN) begin
      eq_len_out = `EQC_COAX_MAX_LEN;
    end else begin
      eq_len_out = manual_len_in;
    end
  end

  always_comb begin
    if (!HAS_FILTER) begin
      filter_out = eqc_pkg::EQC_FILT_NONE;
    end else if (mode_ff[`EQC_FILT_LSB + 1]) begin
      filter_out = eqc_pkg::EQC_FILT_MAX;
    end else if (mode_ff[`EQC_FILT_LSB]) begin
      filter_out = eqc_pkg::EQC_FILT_MIN;
    end else begin
      filter_out = eqc_pkg::EQC_FILT_NONE;
    end
  end

  // Absence counter: any return of the signal restarts the wait.
  assign loss_done = (loss_cnt_ff == 32'(LOSS_CYCLES - 1));
  always_ff @(posedge clk_in) begin
    if (!resetn_in || signal_present_in || lock_ff != eqc_pkg::EQC_LK_LOCKED
        || mode != eqc_pkg::EQC_MODE_LOSS) begin
      loss_cnt_ff <= 32'h0000_0000;
    end else if (!loss_done) begin
      loss_cnt_ff <= loss_cnt_ff + 32'h0000_0001;
    end
  end

  // Locking does not depend on the hold pin, so hold is kept apart.
  always_comb begin
    nxt_lock = lock_ff;
    case (lock_ff)
      eqc_pkg::EQC_LK_ADAPT: begin
        if ((mode == eqc_pkg::EQC_MODE_LOSS ||
             mode == eqc_pkg::EQC_MODE_RESET) && settled_in) begin
          nxt_lock = eqc_pkg::EQC_LK_LOCKED;
        end
      end
      eqc_pkg::EQC_LK_LOCKED: begin
        if (mode == eqc_pkg::EQC_MODE_CONT ||
            mode == eqc_pkg::EQC_MODE_MANUAL) begin
          nxt_lock = eqc_pkg::EQC_LK_ADAPT;
        end else if (mode == eqc_pkg::EQC_MODE_LOSS && loss_done) begin
          nxt_lock = eqc_pkg::EQC_LK_ADAPT;
        end
      end
      default: nxt_lock = eqc_pkg::EQC_LK_ADAPT;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      lock_ff <= eqc_pkg::EQC_LK_ADAPT;
    end else begin
      lock_ff <= nxt_lock;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      restart_ff <= 1'h0;
    end else begin
      restart_ff <= (lock_ff == eqc_pkg::EQC_LK_LOCKED) &&
                    (mode == eqc_pkg::EQC_MODE_LOSS) && loss_done;
    end
  end

  assign lock_out = (lock_ff == eqc_pkg::EQC_LK_LOCKED);
  assign restart_out = restart_ff;

endmodule

// ---- tb/eqc_ctrl_assertions.sv ----
// Concurrent checks on the outputs of the equalizer control bank.
module eqc_chk #(
  parameter int LOSS_CYCLES = 20 // Loss time.
) (
  input wire logic clk_in, // Clock.
  input wire logic resetn_in, // Reset.
  input wire logic signal_present_in, // Signal.
  input wire logic settled_in, // Settled.
  input wire logic [5:0] manual_len_in, // Length.
  input wire logic auto_pol_en_out, // Corrector.
  input wire eqc_pkg::eqc_mode_e mode_out, // Mode.
  input wire logic lock_out, // Locked.
  input wire logic restart_out, // Restart.
  input wire logic manual_out, // Manual.
  input wire logic signed [6:0] gain_step_out, // Gain.
  input wire logic [5:0] eq_len_out, // Length used.
  input wire logic coax_out, // Coax.
  input wire eqc_pkg::eqc_filt_e filter_out // Filter.
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  // Counts absence regardless of lock, so it never undercounts the timer.
  int miss_ff;
  always_ff @(posedge clk_in) begin
    if (!resetn_in || signal_present_in) begin
      miss_ff <= 0;
    end else begin
      miss_ff <= miss_ff + 1;
    end
  end
  a_pol_manual: assert property (auto_pol_en_out == !manual_out)
    else $error("corrector enable wrong");
  a_manual_dec: assert property (
    manual_out == (mode_out == eqc_pkg::EQC_MODE_MANUAL))
    else $error("manual decode wrong");
  a_gain_idle: assert property (!manual_out |-> gain_step_out == 7'sh00)
    else $error("gain outside manual");
  a_gain_range: assert property (manual_out |->
    gain_step_out <= 7'sh20 && gain_step_out >= -7'sh1F)
    else $error("gain out of range");
  a_cable_idle: assert property (!manual_out |-> !coax_out)
    else $error("cable bit used");
  a_len_cap: assert property (manual_out |-> eq_len_out ==
    ((coax_out && manual_len_in > 6'h14) ? 6'h14 : manual_len_in))
    else $error("length wrong");
  a_filter_code: assert property (filter_out != 2'h3)
    else $error("filter code wrong");
  a_lock_mode: assert property (lock_out |->
    $past(mode_out) inside {eqc_pkg::EQC_MODE_LOSS, eqc_pkg::EQC_MODE_RESET})
    else $error("lock in wrong mode");
  a_loss_wait: assert property (restart_out |->
    miss_ff >= LOSS_CYCLES - 1 && !lock_out)
    else $error("restart too early");
  a_reset_hold: assert property (lock_out &&
    mode_out == eqc_pkg::EQC_MODE_RESET ##1
    mode_out == eqc_pkg::EQC_MODE_RESET |-> lock_out)
    else $error("reset lock lost");
  a_settle_lock: assert property (settled_in && !lock_out &&
    mode_out inside {eqc_pkg::EQC_MODE_LOSS, eqc_pkg::EQC_MODE_RESET}
    |=> lock_out || $changed(mode_out))
    else $error("no lock");
  c_restart: cover property (restart_out);
  c_cap: cover property (coax_out && manual_len_in > 6'h14);
  c_hold: cover property (lock_out && mode_out == eqc_pkg::EQC_MODE_RESET);
endmodule

bind eqc_ctrl eqc_chk #(.LOSS_CYCLES(LOSS_CYCLES)) chk_u (
  .clk_in(clk_in), .resetn_in(resetn_in),
  .signal_present_in(signal_present_in), .settled_in(settled_in),
  .manual_len_in(manual_len_in), .auto_pol_en_out(auto_pol_en_out),
  .mode_out(mode_out), .lock_out(lock_out), .restart_out(restart_out),
  .manual_out(manual_out), .gain_step_out(gain_step_out),
  .eq_len_out(eq_len_out), .coax_out(coax_out), .filter_out(filter_out));

// ---- tb/eqc_host.sv ----
// Host controller model for the serial control port.
module eqc_host (
  input wire logic clk_in, // Clock.
  input wire logic sd_in, // Data line level.
  output logic frame_en_out, // Frame.
  output logic sck_out, // Serial clock.
  output logic sd_out // Host data.
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    frame_en_out = 1'b0;
    sck_out = 1'b0;
    sd_out = 1'b0;
  end
  task automatic xfer(input logic r, input logic [6:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic [15:0] w;
    w = {r, a, d};
    q = 8'h00;
    @(negedge clk_in);
    frame_en_out = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk_in);
      sck_out = 1'b0;
      // Released line toggles so a silent device never reads as valid.
      sd_out = (r && i < 8) ? ~sd_out : w[i];
      repeat (2) @(negedge clk_in);
      sck_out = 1'b1;
      repeat (2) @(negedge clk_in);
      q[i % 8] = sd_in;
    end
    @(negedge clk_in);
    sck_out = 1'b0;
    frame_en_out = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask
endmodule

// ---- tb/tb_equalizer_control_registers.sv ----
// Self-checking bench for the equalizer control register bank.
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_equalizer_control_registers;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOSS = 20;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic frame_en, sck, host_sd, dut_sd, oe_n, sd_w;
  logic hold_pin = 1'b0, off_pin = 1'b0, color_pin = 1'b0, inv_pin = 1'b0;
  logic auto_inv = 1'b0, present = 1'b1, settled = 1'b0;
  logic [5:0] len_in = 6'h00;
  logic hold, eq_off, color, inv, auto_pol, lock, restart, man, coax;
  logic [1:0] mode, filt;
  logic signed [6:0] gain;
  logic [5:0] eq_len, xl;
  logic [7:0] q, v;
  int n_fail = 0, check_count = 0, cyc = 0, n;
  logic [5:0] gl [3] = '{6'h00, 6'h20, 6'h3F};
  assign sd_w = oe_n ? host_sd : dut_sd;
  always #5 clk_in = ~clk_in;
  eqc_host host_u (.clk_in(clk_in), .sd_in(sd_w), .frame_en_out(frame_en),
    .sck_out(sck), .sd_out(host_sd));
  eqc_ctrl #(.LOSS_CYCLES(LOSS), .HAS_FILTER(1'b1)) dut_u (.clk_in(clk_in),
    .resetn_in(resetn_in), .frame_en_in(frame_en), .sck_in(sck),
    .sd_in(sd_w), .sd_out(dut_sd), .sd_oe_n_out(oe_n),
    .hold_pin_in(hold_pin), .eq_off_pin_in(off_pin),
    .color_pin_in(color_pin), .invert_pin_in(inv_pin),
    .auto_invert_in(auto_inv), .signal_present_in(present),
    .settled_in(settled), .manual_len_in(len_in), .hold_out(hold),
    .eq_off_out(eq_off), .color_mode_out(color), .invert_out(inv),
    .auto_pol_en_out(auto_pol), .mode_out(mode), .lock_out(lock),
    .restart_out(restart), .manual_out(man), .gain_step_out(gain),
    .eq_len_out(eq_len), .coax_out(coax), .filter_out(filt));
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.xfer(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    host_u.xfer(1'b1, a, 8'h00, q);
    `CHK(q, e)
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Run is about 29000 cycles; the ceiling leaves ample margin.
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    repeat (3) @(negedge clk_in);
    resetn_in = 1'b1;
    rd(7'h03, 8'h20);
    rd(7'h04, 8'h00);
    rd(7'h05, 8'h00);
    wr(7'h06, 8'h5A);
    rd(7'h06, 8'h00);
    wr(7'h05, 8'h03);
    wr(7'h03, 8'hFF);
    rd(7'h03, 8'h3F);
    for (int i = 0; i < 3; i++) begin
      wr(7'h03, {2'h0, gl[i]});
      `CHK(gain, 7'sh20 - $signed({1'b0, gl[i]}))
    end
    wr(7'h05, 8'h00);
    `CHK(gain, 7'sh00)
    for (int i = 0; i < 256; i++) begin
      v = 8'(i);
      {inv_pin, color_pin, off_pin, hold_pin} = v[3:0] ^ v[7:4];
      auto_inv = ~inv_pin;
      wr(7'h04, v);
      `CHK(hold, v[0] ? v[1] : hold_pin)
      `CHK(eq_off, v[2] ? v[3] : off_pin)
      `CHK(color, v[4] ? v[5] : color_pin)
      `CHK(inv, v[6] ? v[7] : auto_inv)
    end
    rd(7'h04, 8'hFF);
    inv_pin = 1'b1;
    auto_inv = 1'b0;
    wr(7'h04, 8'h00);
    wr(7'h05, 8'h03);
    `CHK(inv, 1'b1)
    `CHK(auto_pol, 1'b0)
    for (int i = 0; i < 32; i++) begin
      v = 8'(i);
      len_in = v[5:0];
      wr(7'h05, v | 8'hE0);
      rd(7'h05, v);
      xl = (v[4] && v > 8'h14) ? 6'h14 : v[5:0];
      `CHK(mode, v[1:0])
      `CHK(coax, &v[1:0] & v[4])
      `CHK(eq_len, (&v[1:0]) ? xl : 6'h00)
      `CHK(filt, v[3] ? 2'h2 : {1'b0, v[2]})
    end
    hold_pin = 1'b0;
    settled = 1'b1;
    wr(7'h05, 8'h01);
    `CHK(lock, 1'b1)
    settled = 1'b0;
    present = 1'b0;
    n = 0;
    while (restart !== 1'b1 && n < 100) begin
      @(negedge clk_in);
      n++;
    end
    `CHK(n inside {[LOSS - 1:LOSS + 1]}, 1'b1)
    `CHK(lock, 1'b0)
    present = 1'b1;
    settled = 1'b1;
    wr(7'h05, 8'h02);
    `CHK(lock, 1'b1)
    settled = 1'b0;
    present = 1'b0;
    repeat (3 * LOSS) @(negedge clk_in);
    `CHK(lock, 1'b1)
    wr(7'h05, 8'h00);
    `CHK(lock, 1'b0)
    wr(7'h03, 8'h11);
    resetn_in = 1'b0;
    @(negedge clk_in);
    resetn_in = 1'b1;
    rd(7'h03, 8'h20);
    close_out();
  end
endmodule
